// file: logic/rmon_adc_regs.vh
`ifndef RMON_ADC_REGS_VH
`define RMON_ADC_REGS_VH

// Byte addresses on the register bus.
`define RMON_ADDR_STATUS 32'hffff0500
`define RMON_ADDR_MODE 32'hffff0504
`define RMON_ADDR_CTRL 32'hffff0508
`define RMON_ADDR_CFG 32'hffff050c
`define RMON_ADDR_CUR_RES 32'hffff0520
`define RMON_ADDR_VOLT_RES 32'hffff0524
`define RMON_ADDR_TEMP_RES 32'hffff0528
`define RMON_ADDR_OFF0 32'hffff0530
`define RMON_ADDR_OFF1 32'hffff0534
`define RMON_ADDR_OFF2 32'hffff0538
`define RMON_ADDR_GAIN0 32'hffff053c
`define RMON_ADDR_GAIN1 32'hffff0540
`define RMON_ADDR_GAIN2 32'hffff0544
`define RMON_ADDR_STEP 32'h00000004
`define RMON_ADDR_RCL 32'hffff0548
`define RMON_ADDR_RCV 32'hffff054c
`define RMON_ADDR_TH 32'hffff0550
`define RMON_ADDR_TCL 32'hffff0554
`define RMON_ADDR_THV 32'hffff0558
`define RMON_ADDR_ACC 32'hffff055c

// Reset values.
`define RMON_RST_W16 16'h0000
`define RMON_RST_W8 8'h00
`define RMON_RST_W32 32'h00000000
`define RMON_RST_RCL 16'h0001
`define RMON_RST_TCL 8'h01

// Status bits.
`define RMON_STA_CUR 0
`define RMON_STA_VOLT 1
`define RMON_STA_TEMP 2

// Configuration fields.
`define RMON_CFG_CNT_EN 0
`define RMON_CFG_CMP_LSB 3
`define RMON_CFG_ACC_LSB 5

// Current channel control fields.
`define RMON_CTRL_UNI 5
`define RMON_CTRL_EN 15

// Mode register field and the idle code.
`define RMON_MODE_LSB 0
`define RMON_MODE_IDLE 3'h3

// Comparator and accumulator mode codes.
`define RMON_CMP_OFF 2'h0
`define RMON_CMP_EACH 2'h1
`define RMON_CMP_CLR 2'h2
`define RMON_CMP_DEC 2'h3
`define RMON_ACC_OFF 2'h0
`define RMON_ACC_CLAMP 2'h1
`define RMON_ACC_SIGNED 2'h2

// Factory calibration vector layout.
`define RMON_GAIN_FACT_LSB 48

// Least idle time before calibration writes are accepted.
`define RMON_IDLE_MIN_NS 23000
`define RMON_CLK_PERIOD_NS 25
`define RMON_IDLE_CYCLES ((`RMON_IDLE_MIN_NS + `RMON_CLK_PERIOD_NS - 1) / `RMON_CLK_PERIOD_NS)
`define RMON_IDLE_CNT_W 10

`endif

// file: logic/rmon_adc_result_regs.v
// Functional notes
// - Current result holds while its ready flag is set; no overwrite then.
// - Reading the current result clears all three ready flags.
// - Voltage result holds while its ready flag is set; newer results dropped.
// - With current channel inactive, voltage read clears voltage and temperature flags.
// - Temperature result holds while flagged; reading it clears its flag.
// - Offset coefficients load factory values, replaced by offset calibration.
// - Gain coefficients load factory values, replaced by gain calibration.
// - Result count limit, reset one, acts only with counter enabled.
// - Result count increments per current conversion, returns to zero at limit.
// - Writing control or mode register clears the result count.
// - Absolute result versus threshold; bit 15 ignored in twos complement.
// - Threshold count reaching its limit sets comparator flag and interrupt.
// - Threshold count rises at or above threshold, else clears or decrements.
// - Accumulator holds running total, cleared when disabled or reconfigured.
// - Accumulator mode one clamps at zero, mode two goes negative.
// - Comparator modes: off, each result, count with clear, count with decrement.
// - With counter enabled, current interrupt only when count reaches limit.
`timescale 1ns/1ps
`default_nettype none
`include "rmon_adc_regs.vh"

module rmon_adc_result_regs (
    input wire ref_clk,
    input wire rst,
    input wire [31:0] busAddr,
    input wire busWrEn,
    input wire busRdEn,
    input wire [31:0] busWrData,
    output reg [31:0] busRdData,
    input wire curValid,
    input wire [15:0] curData,
    input wire voltValid,
    input wire [15:0] voltData,
    input wire tempValid,
    input wire [15:0] tempData,
    input wire [2:0] calOffLoad,
    input wire [2:0] calGainLoad,
    input wire [15:0] calData,
    input wire [95:0] factoryCal,
    output wire [7:0] converterMode,
    output wire [15:0] currentControl,
    output wire [7:0] converterConfig,
    output wire adcIrq
);

    localparam integer IDLE_CYC_FULL = `RMON_IDLE_CYCLES;
    localparam [`RMON_IDLE_CNT_W-1:0] IDLE_CYC = IDLE_CYC_FULL[`RMON_IDLE_CNT_W-1:0];

    reg [7:0] mode_ff;
    reg [15:0] ctrl_ff;
    reg [7:0] cfg_ff;
    reg [15:0] rcl_ff;
    reg [15:0] rcv_ff;
    reg [15:0] th_ff;
    reg [7:0] tcl_ff;
    reg [7:0] thv_ff;
    reg [31:0] acc_ff;
    reg cntHit_ff;
    reg cmpFlag_ff;
    reg [`RMON_IDLE_CNT_W-1:0] idleCnt_ff;
    reg [7:0] nxt_thv;
    reg cmpSet;
    reg [31:0] nxt_acc;
    reg [31:0] rdMux;

    wire [2:0] rdy;
    wire [2:0] rdyClr;
    wire [2:0] resValid = {tempValid, voltValid, curValid};
    wire [47:0] resIn = {tempData, voltData, curData};
    wire [47:0] resFlat;
    wire [47:0] offFlat;
    wire [47:0] gainFlat;

    wire rdCur = busRdEn & (busAddr == `RMON_ADDR_CUR_RES);
    wire rdVolt = busRdEn & (busAddr == `RMON_ADDR_VOLT_RES);
    wire rdTemp = busRdEn & (busAddr == `RMON_ADDR_TEMP_RES);
    wire rdStatus = busRdEn & (busAddr == `RMON_ADDR_STATUS);
    wire modeWr = busWrEn & (busAddr == `RMON_ADDR_MODE);
    wire ctrlWr = busWrEn & (busAddr == `RMON_ADDR_CTRL);
    wire cfgWr = busWrEn & (busAddr == `RMON_ADDR_CFG);
    wire curActive = ctrl_ff[`RMON_CTRL_EN];
    wire reconfig = modeWr | ctrlWr;
    wire calWrOk = (idleCnt_ff == IDLE_CYC);

    assign rdyClr[`RMON_STA_CUR] = rdCur;
    assign rdyClr[`RMON_STA_VOLT] = rdCur | (rdVolt & ~curActive);
    assign rdyClr[`RMON_STA_TEMP] = rdCur | (rdVolt & ~curActive) | rdTemp;

    // The calibration engine delivers its coefficient on the load strobes; a
    // load in the same cycle as a bus write wins, so a fresh calibration is kept.
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : chan
            reg [15:0] res_ff;
            reg rdy_ff;
            reg [15:0] off_ff;
            reg [15:0] gain_ff;
            // A clearing read in the same cycle frees the slot for the new result.
            wire take = resValid[i] & (~rdy_ff | rdyClr[i]);
            wire offWr = busWrEn & calWrOk &
                (busAddr == `RMON_ADDR_OFF0 + i * `RMON_ADDR_STEP);
            wire gainWr = busWrEn & calWrOk &
                (busAddr == `RMON_ADDR_GAIN0 + i * `RMON_ADDR_STEP);
            always @(posedge ref_clk) begin
                if (rst) begin
                    res_ff <= `RMON_RST_W16;
                    rdy_ff <= 1'b0;
                end else begin
                    if (take) begin
                        res_ff <= resIn[i*16 +: 16];
                    end
                    if (take) begin
                        rdy_ff <= 1'b1;
                    end else if (rdyClr[i]) begin
                        rdy_ff <= 1'b0;
                    end
                end
            end
            always @(posedge ref_clk) begin
                if (rst) begin
                    off_ff <= factoryCal[i*16 +: 16];
                    gain_ff <= factoryCal[`RMON_GAIN_FACT_LSB + i*16 +: 16];
                end else begin
                    if (calOffLoad[i]) begin
                        off_ff <= calData;
                    end else if (offWr) begin
                        off_ff <= busWrData[15:0];
                    end
                    if (calGainLoad[i]) begin
                        gain_ff <= calData;
                    end else if (gainWr) begin
                        gain_ff <= busWrData[15:0];
                    end
                end
            end
            assign rdy[i] = rdy_ff;
            assign resFlat[i*16 +: 16] = res_ff;
            assign offFlat[i*16 +: 16] = off_ff;
            assign gainFlat[i*16 +: 16] = gain_ff;
        end
    endgenerate

    // Calibration writes are refused until the converter has idled long enough with the current channel enabled,
    // because the coefficients are in use by the filter at any other time.
    always @(posedge ref_clk) begin
        if (rst) begin
            idleCnt_ff <= {`RMON_IDLE_CNT_W{1'b0}};
        end else if (mode_ff[`RMON_MODE_LSB +: 3] != `RMON_MODE_IDLE || !curActive) begin
            idleCnt_ff <= {`RMON_IDLE_CNT_W{1'b0}};
        end else if (!calWrOk) begin
            idleCnt_ff <= idleCnt_ff + {{(`RMON_IDLE_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    wire cntEn = cfg_ff[`RMON_CFG_CNT_EN];
    wire [15:0] cntNext = rcv_ff + 16'h0001;
    wire cntHitNow = cntEn & curValid & (cntNext == rcl_ff);

    always @(posedge ref_clk) begin
        if (rst) begin
            rcv_ff <= `RMON_RST_W16;
        end else if (reconfig) begin
            rcv_ff <= `RMON_RST_W16;
        end else if (cntEn & curValid) begin
            rcv_ff <= cntHitNow ? `RMON_RST_W16 : cntNext;
        end
    end

    wire uni = ctrl_ff[`RMON_CTRL_UNI];
    wire neg = ~uni & curData[15];
    wire [15:0] mag = neg ? (~curData + 16'h0001) : curData;
    wire [15:0] thEff = uni ? th_ff : {1'b0, th_ff[14:0]};
    wire meets = (mag >= thEff);
    wire [1:0] cmpMode = cfg_ff[`RMON_CFG_CMP_LSB +: 2];
    wire [1:0] accMode = cfg_ff[`RMON_CFG_ACC_LSB +: 2];

    always @* begin
        nxt_thv = thv_ff;
        cmpSet = 1'b0;
        if (curValid) begin
            case (cmpMode)
                `RMON_CMP_EACH: begin
                    cmpSet = meets;
                end
                `RMON_CMP_CLR, `RMON_CMP_DEC: begin
                    if (meets) begin
                        if (thv_ff != 8'hff) begin
                            nxt_thv = thv_ff + 8'h01;
                        end
                        cmpSet = (nxt_thv == tcl_ff);
                    end else if (cmpMode == `RMON_CMP_CLR) begin
                        nxt_thv = `RMON_RST_W8;
                    end else if (thv_ff != `RMON_RST_W8) begin
                        nxt_thv = thv_ff - 8'h01;
                    end
                end
                default: begin
                    nxt_thv = thv_ff;
                end
            endcase
        end
    end

    // Mode one treats the total as unsigned and floors it at zero; mode two
    // wraps in twos complement. Positive overflow wraps in both.
    always @* begin
        nxt_acc = acc_ff;
        case (accMode)
            `RMON_ACC_CLAMP: begin
                if (!neg) begin
                    nxt_acc = acc_ff + {16'h0000, mag};
                end else if (acc_ff < {16'h0000, mag}) begin
                    nxt_acc = `RMON_RST_W32;
                end else begin
                    nxt_acc = acc_ff - {16'h0000, mag};
                end
            end
            `RMON_ACC_SIGNED: begin
                nxt_acc = neg ? acc_ff - {16'h0000, mag} : acc_ff + {16'h0000, mag};
            end
            default: begin
                nxt_acc = acc_ff;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            thv_ff <= `RMON_RST_W8;
            acc_ff <= `RMON_RST_W32;
            cntHit_ff <= 1'b0;
            cmpFlag_ff <= 1'b0;
        end else begin
            thv_ff <= nxt_thv;
            if (accMode == `RMON_ACC_OFF || reconfig) begin
                acc_ff <= `RMON_RST_W32;
            end else if (curValid) begin
                acc_ff <= nxt_acc;
            end
            if (cntHitNow) begin
                cntHit_ff <= 1'b1;
            end else if (rdCur) begin
                cntHit_ff <= 1'b0;
            end
            if (cmpSet) begin
                cmpFlag_ff <= 1'b1;
            end else if (rdStatus) begin
                cmpFlag_ff <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            mode_ff <= `RMON_RST_W8;
            ctrl_ff <= `RMON_RST_W16;
            cfg_ff <= `RMON_RST_W8;
            rcl_ff <= `RMON_RST_RCL;
            th_ff <= `RMON_RST_W16;
            tcl_ff <= `RMON_RST_TCL;
        end else if (busWrEn) begin
            case (busAddr)
                `RMON_ADDR_MODE: mode_ff <= busWrData[7:0];
                `RMON_ADDR_CTRL: ctrl_ff <= busWrData[15:0];
                `RMON_ADDR_CFG: cfg_ff <= busWrData[7:0];
                `RMON_ADDR_RCL: rcl_ff <= busWrData[15:0];
                `RMON_ADDR_TH: th_ff <= busWrData[15:0];
                `RMON_ADDR_TCL: tcl_ff <= busWrData[7:0];
                default: begin
                    mode_ff <= mode_ff;
                end
            endcase
        end
    end

    always @* begin
        rdMux = `RMON_RST_W32;
        case (busAddr)
            `RMON_ADDR_STATUS: rdMux = {27'h0000000, cntHit_ff, cmpFlag_ff, rdy};
            `RMON_ADDR_MODE: rdMux = {24'h000000, mode_ff};
            `RMON_ADDR_CTRL: rdMux = {16'h0000, ctrl_ff};
            `RMON_ADDR_CFG: rdMux = {24'h000000, cfg_ff};
            `RMON_ADDR_CUR_RES: rdMux = {16'h0000, resFlat[15:0]};
            `RMON_ADDR_VOLT_RES: rdMux = {16'h0000, resFlat[31:16]};
            `RMON_ADDR_TEMP_RES: rdMux = {16'h0000, resFlat[47:32]};
            `RMON_ADDR_OFF0: rdMux = {16'h0000, offFlat[15:0]};
            `RMON_ADDR_OFF1: rdMux = {16'h0000, offFlat[31:16]};
            `RMON_ADDR_OFF2: rdMux = {16'h0000, offFlat[47:32]};
            `RMON_ADDR_GAIN0: rdMux = {16'h0000, gainFlat[15:0]};
            `RMON_ADDR_GAIN1: rdMux = {16'h0000, gainFlat[31:16]};
            `RMON_ADDR_GAIN2: rdMux = {16'h0000, gainFlat[47:32]};
            `RMON_ADDR_RCL: rdMux = {16'h0000, rcl_ff};
            `RMON_ADDR_RCV: rdMux = {16'h0000, rcv_ff};
            `RMON_ADDR_TH: rdMux = {16'h0000, th_ff};
            `RMON_ADDR_TCL: rdMux = {24'h000000, tcl_ff};
            `RMON_ADDR_THV: rdMux = {24'h000000, thv_ff};
            `RMON_ADDR_ACC: rdMux = acc_ff;
            default: rdMux = `RMON_RST_W32;
        endcase
    end

    // Read data is captured on the read strobe and returned the next cycle.
    always @(posedge ref_clk) begin
        if (rst) begin
            busRdData <= `RMON_RST_W32;
        end else if (busRdEn) begin
            busRdData <= rdMux;
        end
    end

    assign converterMode = mode_ff;
    assign currentControl = ctrl_ff;
    assign converterConfig = cfg_ff;
    assign adcIrq = (cntEn ? cntHit_ff : rdy[`RMON_STA_CUR]) | cmpFlag_ff;

endmodule

`default_nettype wire

// file: verif/rmon_adc_result_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmon_adc_regs.vh"
module rmon_adc_result_regs_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] busAddr,
    input wire logic busWrEn,
    input wire logic busRdEn,
    input wire logic [31:0] busWrData,
    input wire logic [31:0] busRdData,
    input wire logic curValid,
    input wire logic [15:0] curData,
    input wire logic [7:0] converterMode,
    input wire logic [15:0] currentControl,
    input wire logic [7:0] converterConfig,
    input wire logic adcIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // With counting off and no interrupt, the ready flag is known clear, so the result lands.
    sequence s_newCur;
        curValid && !adcIrq && !converterConfig[0] && !busWrEn && !busRdEn
            ##1 !curValid && !busRdEn;
    endsequence
    sequence s_modeClr;
        busWrEn && busAddr == `RMON_ADDR_MODE ##1 !curValid;
    endsequence
    unmapped_read_a: assert property (busRdEn && busAddr[31:8] != 24'hffff05 |=>
        busRdData == 32'h0) else $error("unmapped read not zero");
    cfg_write_a: assert property (busWrEn && busAddr == `RMON_ADDR_CFG |=>
        converterConfig == $past(busWrData[7:0])) else $error("config write lost");
    ctrl_write_a: assert property (busWrEn && busAddr == `RMON_ADDR_CTRL |=>
        currentControl == $past(busWrData[15:0])) else $error("control write lost");
    cfg_hold_a: assert property (!(busWrEn && busAddr == `RMON_ADDR_CFG) |=>
        $stable(converterConfig)) else $error("config changed without write");
    irq_set_a: assert property (curValid && !converterConfig[0] && !busWrEn |=>
        adcIrq) else $error("no interrupt after conversion");
    irq_cause_a: assert property ($rose(adcIrq) && $stable(converterConfig) &&
        converterConfig[4:0] == 5'h0 |-> $past(curValid)) else $error("spurious interrupt");
    cur_data_a: assert property (s_newCur ##1 busRdEn && busAddr == `RMON_ADDR_CUR_RES |=>
        busRdData == {16'h0, $past(curData, 3)}) else $error("current result wrong");
    rd_hold_a: assert property (!busRdEn |=> $stable(busRdData))
        else $error("read data moved without read");
    acc_off_a: assert property (busRdEn && busAddr == `RMON_ADDR_ACC &&
        converterConfig[6:5] == 2'h0 && $stable(converterConfig[6:5]) |=> busRdData == 32'h0)
        else $error("accumulator not cleared");
    count_clear_a: assert property (s_modeClr ##1 busRdEn && busAddr == `RMON_ADDR_RCV |=>
        busRdData == 32'h0) else $error("result count not cleared");
endmodule
bind rmon_adc_result_regs rmon_adc_result_regs_properties checker_i (
    .ref_clk, .rst, .busAddr, .busWrEn, .busRdEn, .busWrData, .busRdData, .curValid,
    .curData, .converterMode, .currentControl, .converterConfig, .adcIrq
);
`default_nettype wire

// file: verif/rmon_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmon_conv_model #(
    parameter logic [95:0] FACTORY = 96'h0
) (
    input wire logic ref_clk,
    output logic curValid,
    output logic [15:0] curData,
    output logic voltValid,
    output logic [15:0] voltData,
    output logic tempValid,
    output logic [15:0] tempData,
    output logic [2:0] calOffLoad,
    output logic [2:0] calGainLoad,
    output logic [15:0] calData,
    output logic [95:0] factoryCal
);
    // Data lines invert once their strobe drops, so a stale word never looks valid.
    initial begin
        {curValid, voltValid, tempValid} = 3'h0;
        {curData, voltData, tempData, calData} = 64'h0;
        {calOffLoad, calGainLoad} = 6'h0;
        factoryCal = FACTORY;
    end
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic send(input logic [1:0] ch, input logic [15:0] d);
        curValid = (ch == 2'h0);
        voltValid = (ch == 2'h1);
        tempValid = (ch == 2'h2);
        {curData, voltData, tempData} = {d, d, d};
        step();
        {curValid, voltValid, tempValid} = 3'h0;
        {curData, voltData, tempData} = ~{d, d, d};
        step();
    endtask
    task automatic load(input logic gain, input logic [2:0] ch, input logic [15:0] d);
        calData = d;
        calGainLoad = gain ? ch : 3'h0;
        calOffLoad = gain ? 3'h0 : ch;
        step();
        {calOffLoad, calGainLoad} = 6'h0;
        calData = ~d;
        step();
    endtask
endmodule
`default_nettype wire

// file: verif/test_adc_result_monitor_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmon_adc_regs.vh"
module test_adc_result_monitor_regs;
    // Factory calibration values are arbitrary.
    localparam logic [95:0] FACT = 96'h6066_5055_4044_3033_2022_1011;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] busAddr = 32'h0;
    logic [31:0] busWrData = 32'h0;
    logic busWrEn = 1'b0;
    logic busRdEn = 1'b0;
    wire logic [31:0] busRdData;
    wire logic curValid, voltValid, tempValid, adcIrq;
    wire logic [15:0] curData, voltData, tempData, calData, currentControl;
    wire logic [2:0] calOffLoad, calGainLoad;
    wire logic [95:0] factoryCal;
    wire logic [7:0] converterMode, converterConfig;
    int fail_count = 0;
    int num_checks = 0;
    always #12.5 ref_clk = ~ref_clk;
    rmon_conv_model #(.FACTORY(FACT)) CONV (.ref_clk, .curValid, .curData, .voltValid,
        .voltData, .tempValid, .tempData, .calOffLoad, .calGainLoad, .calData, .factoryCal);
    rmon_adc_result_regs DUT (.ref_clk, .rst, .busAddr, .busWrEn, .busRdEn, .busWrData,
        .busRdData, .curValid, .curData, .voltValid, .voltData, .tempValid, .tempData,
        .calOffLoad, .calGainLoad, .calData, .factoryCal, .converterMode, .currentControl,
        .converterConfig, .adcIrq);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        busAddr = a;
        busWrData = d;
        busWrEn = 1'b1;
        CONV.step();
        busWrEn = 1'b0;
        CONV.step();
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        busAddr = a;
        busRdEn = 1'b1;
        CONV.step();
        busRdEn = 1'b0;
        chk(busRdData, exp);
        CONV.step();
    endtask
    task automatic irq(input logic e);
        chk({31'h0, adcIrq}, {31'h0, e});
    endtask
    // Current conversion followed by its read, keeping the ready flags clear.
    task automatic conv(input logic [15:0] d);
        CONV.send(2'h0, d);
        rdc(`RMON_ADDR_CUR_RES, {16'h0, d});
    endtask
    task automatic t_reset;
        rdc(`RMON_ADDR_RCL, 32'h1);
        rdc(`RMON_ADDR_TCL, 32'h1);
        rdc(`RMON_ADDR_THV, 32'h0);
        rdc(`RMON_ADDR_ACC, 32'h0);
        rdc(`RMON_ADDR_OFF1, {16'h0, FACT[31:16]});
        rdc(`RMON_ADDR_GAIN2, {16'h0, FACT[95:80]});
        rdc(32'hffff0510, 32'h0);
        rdc(32'h00000010, 32'h0);
        wr(`RMON_ADDR_RCV, 32'h5);
        rdc(`RMON_ADDR_RCV, 32'h0);
    endtask
    task automatic t_ready;
        CONV.send(2'h1, 16'h0a01);
        CONV.send(2'h2, 16'h0b01);
        CONV.send(2'h0, 16'h1234);
        CONV.send(2'h0, 16'h5678);
        rdc(`RMON_ADDR_STATUS, 32'h7);
        rdc(`RMON_ADDR_CUR_RES, 32'h1234);
        rdc(`RMON_ADDR_STATUS, 32'h0);
        CONV.send(2'h1, 16'h0aaa);
        CONV.send(2'h1, 16'h0bbb);
        CONV.send(2'h2, 16'h0c00);
        rdc(`RMON_ADDR_VOLT_RES, 32'h0aaa);
        rdc(`RMON_ADDR_STATUS, 32'h0);
        CONV.send(2'h2, 16'h0c01);
        CONV.send(2'h2, 16'h0d01);
        rdc(`RMON_ADDR_TEMP_RES, 32'h0c01);
        rdc(`RMON_ADDR_STATUS, 32'h0);
        wr(`RMON_ADDR_CTRL, 32'h8000);
        CONV.send(2'h1, 16'h0e01);
        rdc(`RMON_ADDR_VOLT_RES, 32'h0e01);
        rdc(`RMON_ADDR_STATUS, 32'h2);
        wr(`RMON_ADDR_CTRL, 32'h0);
        rdc(`RMON_ADDR_CUR_RES, 32'h1234);
    endtask
    task automatic t_count;
        wr(`RMON_ADDR_CFG, 32'h1);
        wr(`RMON_ADDR_RCL, 32'h3);
        CONV.send(2'h0, 16'h0001);
        CONV.send(2'h0, 16'h0002);
        rdc(`RMON_ADDR_RCV, 32'h2);
        irq(1'b0);
        CONV.send(2'h0, 16'h0003);
        rdc(`RMON_ADDR_RCV, 32'h0);
        irq(1'b1);
        rdc(`RMON_ADDR_CUR_RES, 32'h1);
        CONV.send(2'h0, 16'h0004);
        wr(`RMON_ADDR_MODE, 32'h0);
        rdc(`RMON_ADDR_RCV, 32'h0);
        rdc(`RMON_ADDR_CUR_RES, 32'h4);
    endtask
    task automatic t_cmp;
        wr(`RMON_ADDR_TH, 32'h8100);
        wr(`RMON_ADDR_TCL, 32'h2);
        wr(`RMON_ADDR_CFG, 32'h18);
        conv(16'hfe00);
        rdc(`RMON_ADDR_THV, 32'h1);
        conv(16'h0010);
        rdc(`RMON_ADDR_THV, 32'h0);
        conv(16'h0200);
        conv(16'h0300);
        rdc(`RMON_ADDR_THV, 32'h2);
        irq(1'b1);
        rdc(`RMON_ADDR_STATUS, 32'h8);
        wr(`RMON_ADDR_CFG, 32'h10);
        conv(16'h0010);
        rdc(`RMON_ADDR_THV, 32'h0);
        wr(`RMON_ADDR_CFG, 32'h08);
        conv(16'h0100);
        irq(1'b1);
        rdc(`RMON_ADDR_STATUS, 32'h8);
        wr(`RMON_ADDR_CTRL, 32'h0020);
        conv(16'h8000);
        irq(1'b0);
        wr(`RMON_ADDR_CTRL, 32'h0);
    endtask
    task automatic t_acc;
        wr(`RMON_ADDR_CFG, 32'h20);
        conv(16'h0005);
        conv(16'hfff0);
        rdc(`RMON_ADDR_ACC, 32'h0);
        conv(16'h0003);
        rdc(`RMON_ADDR_ACC, 32'h3);
        wr(`RMON_ADDR_CFG, 32'h0);
        rdc(`RMON_ADDR_ACC, 32'h0);
        wr(`RMON_ADDR_CFG, 32'h40);
        conv(16'h0002);
        CONV.send(2'h0, 16'hfffb);
        rdc(`RMON_ADDR_STATUS, 32'h1);
        rdc(`RMON_ADDR_ACC, 32'hfffffffd);
        rdc(`RMON_ADDR_CUR_RES, 32'hfffb);
        wr(`RMON_ADDR_CFG, 32'h60);
        conv(16'h0002);
        rdc(`RMON_ADDR_ACC, 32'hfffffffd);
        wr(`RMON_ADDR_CTRL, 32'h0);
        rdc(`RMON_ADDR_ACC, 32'h0);
        wr(`RMON_ADDR_CFG, 32'h0);
    endtask
    task automatic t_cal;
        wr(`RMON_ADDR_OFF0, 32'hbeef);
        rdc(`RMON_ADDR_OFF0, {16'h0, FACT[15:0]});
        wr(`RMON_ADDR_MODE, 32'h3);
        chk({24'h0, converterMode}, 32'h3);
        wr(`RMON_ADDR_CTRL, 32'h8000);
        repeat (930) CONV.step();
        wr(`RMON_ADDR_OFF0, 32'hbeef);
        rdc(`RMON_ADDR_OFF0, 32'hbeef);
        CONV.load(1'b0, 3'h4, 16'h1111);
        rdc(`RMON_ADDR_OFF2, 32'h1111);
        CONV.load(1'b1, 3'h2, 16'h2222);
        rdc(`RMON_ADDR_GAIN1, 32'h2222);
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_ready();
        t_count();
        t_cmp();
        t_acc();
        t_cal();
        test_done();
    end
endmodule
`default_nettype wire
